// ### core/flcfg_pkg.sv
// Constants and carrier types for the serial flash register and read logic.
// Assumes a 200 MHz system clock and an SPI mode 0/3 host on the link.
package flcfg_pkg;
  // Opcodes
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] STATUS_HI_WRITE_CMD = 8'h31;
  localparam logic [7:0] CONFIG_WRITE_CMD = 8'h11;
  localparam logic [7:0] CONFIG_READ_CMD = 8'h15;
  localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
  localparam logic [7:0] FAST_ARRAY_READ_CMD = 8'h0b;
  localparam logic [7:0] READ_PARAM_CMD = 8'hc0;
  // Frame bit counts
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ONE = 6'h10;
  localparam logic [5:0] BITS_TWO = 6'h18;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_FAST = 6'h28;
  localparam logic [5:0] BITS_MAX = 6'h3f;
  // Configuration byte fields
  localparam int CFG_HOLD_BIT = 7;
  localparam int CFG_DRV_HI_BIT = 6;
  localparam int CFG_DRV_LO_BIT = 5;
  localparam int CFG_SCHEME_BIT = 2;
  localparam int CFG_DUMMY_BIT = 1;
  localparam int CFG_LEARN_BIT = 0;
  localparam logic [7:0] CFG_RSVD_MASK = 8'h18;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam logic [15:0] STAT_FIXED_MASK = 16'h8403;
  localparam logic [15:0] STAT_RESET = 16'h0200;
  // Drive strength in percent
  localparam logic [7:0] DRV_PCT_00 = 8'h64;
  localparam logic [7:0] DRV_PCT_01 = 8'h32;
  localparam logic [7:0] DRV_PCT_10 = 8'h7d;
  localparam logic [7:0] DRV_PCT_11 = 8'h96;
  // Dummy clock counts
  localparam logic [3:0] DUMMY_2IO_LO = 4'h4;
  localparam logic [3:0] DUMMY_2IO_HI = 4'h8;
  localparam logic [3:0] DUMMY_4IO_LO = 4'h6;
  localparam logic [3:0] DUMMY_4IO_HI = 4'ha;
  localparam logic [3:0] DUMMY_DTR4_LO = 4'h8;
  localparam logic [3:0] DUMMY_DTR4_HI = 4'ha;
  localparam logic [3:0] DUMMY_FAST_SPI = 4'h8;
  localparam logic [15:0] DUMMY_FAST_QPI = 16'h8864;
  localparam logic [7:0] LEARN_PATTERN = 8'h34;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int TW_NS_DEFAULT = 5000;

  typedef struct packed {
    logic [7:0] drive_pct;
    logic [3:0] dummy_2io;
    logic [3:0] dummy_4io;
    logic [3:0] dummy_dtr4;
    logic [3:0] fast_dummy;
    logic [7:0] learn_pattern;
    logic lock_scheme;
    logic hold_sel;
  } flcfg_ctrl_type;
endpackage

// ### core/flcfg_top.sv
// Register, status-write and serial read logic of a serial flash device.
// Assumes the host holds CS_N high at start and keeps SCLK still outside frames.
// How it works
// - Configuration read is served at any time, busy or not.
// - Configuration read shifts the byte out on the serial output only.
// - Configuration byte holds hold, drive, scheme, dummy, learning bits; resets to zero.
// - Drive field selects 100, 50, 125 or 150 percent output drive.
// - Scheme bit picks block-protect bits or individual block locks.
// - All individual block locks come up set after reset.
// - Dummy bit sets dummy clocks for 2IO, 4IO and DTR 4IO reads.
// - Learning bit enables the 00110100 pattern during DTR dummy clocks.
// - Status and configuration writes need a prior write enable setting the latch; read parameter writes do not.
// - Status write data never changes bits 15, 10, 1 and 0.
// - Status write ends exactly after 8 data bits, or 16 with opcode 01 only, else dropped.
// - One-byte status write with opcode 01 keeps the upper status byte.
// - Valid status write starts timed busy cycle, then clears busy and latch.
// - Opcodes 01 and 31 both write status values.
// - Configuration write needs exactly one data byte, else rejected.
// - Valid configuration write runs the same timed busy cycle.
// - Address sampled on rising clock, data shifted on falling clock.
// - Read address increments per byte and wraps to zero.
// - Fast read takes address plus one dummy byte before data.
// - Fast read is refused while a write cycle runs.
// - In four-line mode fast read dummy count follows read parameter bits.
// - Status bit 0 shows busy, bit 1 shows the write enable latch.
`timescale 1ns/1ps
module flcfg_top #(
  parameter int TW_NS = flcfg_pkg::TW_NS_DEFAULT,
  parameter int MEM_AW = 8,
  parameter int LOCK_N = 16
) (
  // System
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO_O,
  output logic SO_OE,
  // Array image load
  input wire logic MEM_WR,
  input wire logic [MEM_AW-1:0] MEM_ADDR,
  input wire logic [7:0] MEM_DATA,
  // Mode
  input wire logic FOUR_LINE_MODE,
  // Register view
  output logic [15:0] STATUS_WORD,
  output logic [7:0] CONFIG_BYTE,
  output logic [LOCK_N-1:0] BLOCK_LOCKS,
  output flcfg_pkg::flcfg_ctrl_type CTRL_VIEW
);
  import flcfg_pkg::*;

  localparam int TW_CYC = (TW_NS * CLK_MHZ + 999) / 1000;

  if (MEM_AW < 1 || MEM_AW > 24 || LOCK_N < 1 || TW_CYC < 8) begin : g_bad_param
    $error("flcfg_top: unsupported parameter value");
  end

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic [15:0] stat;
    logic [7:0] cfg;
    logic [7:0] rparam;
    logic [LOCK_N-1:0] locks;
    logic [31:0] tmr;
    flcfg_ctrl_type ctrl;
  } flcfg_ref_type;

  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] op;
    logic [23:0] sh;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [23:0] addr;
    logic [7:0] tx;
    logic [2:0] ph;
    logic send;
    logic from_cfg;
    logic [8:0] s1;
    logic [8:0] s2;
  } flcfg_lnk_type;

  localparam flcfg_ctrl_type CTRL_RESET = '{
    drive_pct: DRV_PCT_00, dummy_2io: DUMMY_2IO_LO, dummy_4io: DUMMY_4IO_LO,
    dummy_dtr4: DUMMY_DTR4_LO, fast_dummy: DUMMY_FAST_SPI,
    learn_pattern: 8'h00, lock_scheme: 1'b0, hold_sel: 1'b0};

  localparam flcfg_ref_type REF_RESET = '{
    cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1, stat: STAT_RESET,
    cfg: CFG_RESET, rparam: 8'h00, locks: '1, tmr: 32'h0, ctrl: CTRL_RESET};

  flcfg_ref_type r_q;
  flcfg_ref_type r_d;
  flcfg_lnk_type l_q;
  flcfg_lnk_type l_d;
  logic act_q;
  logic so_q;
  logic oe_q;
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic frame_end;
  logic wr_st8;
  logic wr_st16;
  logic wr_hi8;
  logic wr_cfg;

  // Array image; written on the system clock, read only by the link
  always_ff @(posedge REF_CLK) begin
    if (MEM_WR) begin
      mem[MEM_ADDR] <= MEM_DATA;
    end
  end

  // Link side, rising SCLK. Only the frame flag is cleared by CS_N; the
  // captured opcode and count must survive the frame end for the system side.
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      act_q <= 1'b0;
    end else begin
      act_q <= 1'b1;
    end
  end

  always_comb begin
    logic [5:0] cnt_now;
    logic [23:0] ra;
    cnt_now = act_q ? l_q.cnt : 6'h00;
    ra = {l_q.sh[22:0], SI};
    l_d = l_q;
    l_d.s1 = {r_q.stat[STAT_BUSY_BIT], r_q.cfg};
    l_d.s2 = l_q.s1;
    l_d.sh = {l_q.sh[22:0], SI};
    l_d.cnt = (cnt_now == BITS_MAX) ? cnt_now : cnt_now + 6'h01;
    if (!act_q) begin
      l_d.send = 1'b0;
    end
    // Shifting goes first, so the byte captures cannot stall a repeating config read
    if (l_q.send && act_q) begin
      if (l_q.ph == 3'h7) begin
        l_d.ph = 3'h0;
        if (l_q.from_cfg) begin
          l_d.tx = l_q.s2[7:0];
        end else begin
          l_d.tx = mem[l_q.addr[MEM_AW-1:0]];
          l_d.addr = l_q.addr + 24'h000001;
        end
      end else begin
        l_d.ph = l_q.ph + 3'h1;
        l_d.tx = {l_q.tx[6:0], 1'b0};
      end
    end else if (l_d.cnt == BITS_OPCODE) begin
      l_d.op = ra[7:0];
      if (ra[7:0] == CONFIG_READ_CMD) begin
        l_d.tx = l_q.s2[7:0];
        l_d.from_cfg = 1'b1;
        l_d.ph = 3'h0;
        l_d.send = 1'b1;
      end
    end else if (l_d.cnt == BITS_ONE) begin
      l_d.b1 = ra[7:0];
    end else if (l_d.cnt == BITS_TWO) begin
      l_d.b2 = ra[7:0];
    end else if (l_d.cnt == BITS_ADDR && l_q.op == ARRAY_READ_CMD) begin
      l_d.tx = mem[ra[MEM_AW-1:0]];
      l_d.addr = ra + 24'h000001;
      l_d.from_cfg = 1'b0;
      l_d.ph = 3'h0;
      l_d.send = 1'b1;
    end else if (l_d.cnt == BITS_ADDR) begin
      l_d.addr = ra;
    end else if (l_d.cnt == BITS_FAST && l_q.op == FAST_ARRAY_READ_CMD) begin
      if (!l_q.s2[8]) begin
        l_d.tx = mem[l_q.addr[MEM_AW-1:0]];
        l_d.addr = l_q.addr + 24'h000001;
        l_d.from_cfg = 1'b0;
        l_d.ph = 3'h0;
        l_d.send = 1'b1;
      end
    end
  end

  always_ff @(posedge SCLK) begin
    l_q <= l_d;
  end

  // Falling SCLK drives data; CS_N high drops the drive at once
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      so_q <= l_q.tx[7];
      oe_q <= l_q.send & act_q;
    end
  end

  // System side. The link fields are read only on the synchronised CS_N
  // rise, two cycles after SCLK has gone still, so they are stable.
  always_comb begin
    logic busy;
    logic write_enable_latch;
    logic ok;
    logic [15:0] cand;
    busy = r_q.stat[STAT_BUSY_BIT];
    write_enable_latch = r_q.stat[STAT_WEL_BIT];
    frame_end = r_q.cs_sync & ~r_q.cs_prev;
    ok = frame_end & write_enable_latch & ~busy;
    wr_st8 = ok && l_q.op == STATUS_WRITE_CMD && l_q.cnt == BITS_ONE;
    wr_st16 = ok && l_q.op == STATUS_WRITE_CMD && l_q.cnt == BITS_TWO;
    wr_hi8 = ok && l_q.op == STATUS_HI_WRITE_CMD && l_q.cnt == BITS_ONE;
    wr_cfg = ok && l_q.op == CONFIG_WRITE_CMD && l_q.cnt == BITS_ONE;
    cand = r_q.stat;
    r_d = r_q;
    r_d.cs_meta = CS_N;
    r_d.cs_sync = r_q.cs_meta;
    r_d.cs_prev = r_q.cs_sync;
    if (wr_st8) begin
      cand = {r_q.stat[15:8], l_q.b1};
    end else if (wr_st16) begin
      cand = {l_q.b2, l_q.b1};
    end else if (wr_hi8) begin
      cand = {l_q.b1, r_q.stat[7:0]};
    end
    if (busy) begin
      if (r_q.tmr == 32'h0) begin
        r_d.stat[STAT_BUSY_BIT] = 1'b0;
        r_d.stat[STAT_WEL_BIT] = 1'b0;
      end else begin
        r_d.tmr = r_q.tmr - 32'h1;
      end
    end else if (frame_end && l_q.op == WRITE_ENABLE_CMD && l_q.cnt == BITS_OPCODE) begin
      r_d.stat[STAT_WEL_BIT] = 1'b1;
    end else if (frame_end && l_q.op == READ_PARAM_CMD && l_q.cnt == BITS_ONE) begin
      r_d.rparam = l_q.b1;
    end else if (wr_st8 || wr_st16 || wr_hi8) begin
      r_d.stat = (cand & ~STAT_FIXED_MASK) | (r_q.stat & STAT_FIXED_MASK);
      r_d.stat[STAT_BUSY_BIT] = 1'b1;
      r_d.tmr = 32'(TW_CYC - 1);
    end else if (wr_cfg) begin
      r_d.cfg = l_q.b1 & ~CFG_RSVD_MASK;
      r_d.stat[STAT_BUSY_BIT] = 1'b1;
      r_d.tmr = 32'(TW_CYC - 1);
    end
    case (r_d.cfg[CFG_DRV_HI_BIT:CFG_DRV_LO_BIT])
      2'b00: r_d.ctrl.drive_pct = DRV_PCT_00;
      2'b01: r_d.ctrl.drive_pct = DRV_PCT_01;
      2'b10: r_d.ctrl.drive_pct = DRV_PCT_10;
      default: r_d.ctrl.drive_pct = DRV_PCT_11;
    endcase
    if (r_d.cfg[CFG_DUMMY_BIT]) begin
      r_d.ctrl.dummy_2io = DUMMY_2IO_HI;
      r_d.ctrl.dummy_4io = DUMMY_4IO_HI;
      r_d.ctrl.dummy_dtr4 = DUMMY_DTR4_HI;
    end else begin
      r_d.ctrl.dummy_2io = DUMMY_2IO_LO;
      r_d.ctrl.dummy_4io = DUMMY_4IO_LO;
      r_d.ctrl.dummy_dtr4 = DUMMY_DTR4_LO;
    end
    if (FOUR_LINE_MODE) begin
      r_d.ctrl.fast_dummy = DUMMY_FAST_QPI[{r_d.rparam[5:4], 2'b00} +: 4];
    end else begin
      r_d.ctrl.fast_dummy = DUMMY_FAST_SPI;
    end
    r_d.ctrl.learn_pattern = r_d.cfg[CFG_LEARN_BIT] ? LEARN_PATTERN : 8'h00;
    r_d.ctrl.lock_scheme = r_d.cfg[CFG_SCHEME_BIT];
    r_d.ctrl.hold_sel = r_d.cfg[CFG_HOLD_BIT];
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      r_q <= REF_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign SO_O = so_q;
  assign SO_OE = oe_q;
  assign STATUS_WORD = r_q.stat;
  assign CONFIG_BYTE = r_q.cfg;
  assign BLOCK_LOCKS = r_q.locks;
  assign CTRL_VIEW = r_q.ctrl;

  // Checks on the system clock
  sequence s_write_start;
    $rose(STATUS_WORD[STAT_BUSY_BIT]);
  endsequence

  sequence s_busy_run;
    STATUS_WORD[STAT_BUSY_BIT] [*8];
  endsequence

  property p_busy_hold;
    @(posedge REF_CLK) disable iff (SYS_RST)
    s_write_start |-> s_busy_run;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("Busy cycle ended too early");

  property p_wel_clear;
    @(posedge REF_CLK) disable iff (SYS_RST)
    $fell(STATUS_WORD[STAT_BUSY_BIT]) |-> !STATUS_WORD[STAT_WEL_BIT];
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("Write latch still set after busy cycle");

  property p_wel_cause;
    @(posedge REF_CLK) disable iff (SYS_RST)
    s_write_start |-> $past(STATUS_WORD[STAT_WEL_BIT]);
  endproperty
  a_wel_cause: assert property (p_wel_cause)
    else $error("Write cycle started without write latch");

  property p_fixed_bits;
    @(posedge REF_CLK) disable iff (SYS_RST)
    !STATUS_WORD[15] && !STATUS_WORD[10];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("Fixed status bit changed");

  property p_wr8_keep;
    @(posedge REF_CLK) disable iff (SYS_RST)
    wr_st8 |=> STATUS_WORD[15:8] == $past(STATUS_WORD[15:8]) && STATUS_WORD[0];
  endproperty
  a_wr8_keep: assert property (p_wr8_keep)
    else $error("One-byte status write changed upper byte");

  property p_cfg_busy;
    @(posedge REF_CLK) disable iff (SYS_RST)
    wr_cfg |=> STATUS_WORD[STAT_BUSY_BIT] && CONFIG_BYTE == ($past(l_q.b1) & ~CFG_RSVD_MASK);
  endproperty
  a_cfg_busy: assert property (p_cfg_busy)
    else $error("Config write did not start busy cycle");

  property p_cfg_rsvd;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CONFIG_BYTE & CFG_RSVD_MASK) == 8'h00;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd)
    else $error("Reserved config bits set");

  property p_lock_reset;
    @(posedge REF_CLK) disable iff (SYS_RST)
    $past(SYS_RST) |-> &BLOCK_LOCKS && CONFIG_BYTE == CFG_RESET;
  endproperty
  a_lock_reset: assert property (p_lock_reset)
    else $error("Block locks not set after reset");

  property p_drive;
    @(posedge REF_CLK) disable iff (SYS_RST)
    CONFIG_BYTE[6:5] == 2'b01 |-> CTRL_VIEW.drive_pct == DRV_PCT_01;
  endproperty
  a_drive: assert property (p_drive)
    else $error("Drive strength mismatch");

  property p_dummy;
    @(posedge REF_CLK) disable iff (SYS_RST)
    CONFIG_BYTE[CFG_DUMMY_BIT] |-> CTRL_VIEW.dummy_4io == DUMMY_4IO_HI;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("Dummy count mismatch");

  property p_learn;
    @(posedge REF_CLK) disable iff (SYS_RST)
    !CONFIG_BYTE[CFG_LEARN_BIT] |-> CTRL_VIEW.learn_pattern == 8'h00;
  endproperty
  a_learn: assert property (p_learn)
    else $error("Learning pattern driven while disabled");

  // Check on the link clock
  property p_fast_wait;
    @(posedge SCLK) disable iff (CS_N)
    act_q && l_q.op == FAST_ARRAY_READ_CMD && l_q.cnt < BITS_FAST |-> !l_q.send;
  endproperty
  a_fast_wait: assert property (p_fast_wait)
    else $error("Fast read data before dummy byte");
endmodule

// ### sim/flcfg_host.sv
// Host-side serial flash controller model for the register and read logic.
// Assumes SPI mode 0 and at least four system clocks of CS_N high between frames.
`timescale 1ns/1ps
module flcfg_host (
  // Link to device
  output logic SCLK,
  output logic CS_N,
  output logic SI,
  // Device answer
  input wire logic SO_O,
  input wire logic SO_OE
);
  // Clock stands low outside frames, so the device sees no stray edges
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end

  // Sends ntx bits MSB first, then clocks nrx more bits and collects SO
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
      output logic [63:0] rx, output logic oe_seen);
    rx = '0;
    oe_seen = 1'b0;
    #1.7;
    CS_N = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      // Released data phase toggles SI so a stale level is never mistaken for data
      SI = (i < ntx) ? tx[ntx-1-i] : ~SI;
      #40;
      SCLK = 1'b1;
      if (i >= ntx) begin
        rx = {rx[62:0], SO_O};
        oe_seen = oe_seen | SO_OE;
      end
      #40;
      SCLK = 1'b0;
    end
    #40;
    CS_N = 1'b1;
    SI = ~SI;
    #100;
  endtask
endmodule

// ### sim/flcfg_top_test.sv
// Self-checking bench for the serial flash register, status-write and read logic.
// Assumes the host model in flcfg_host and a lengthened 8000 ns self-timed write cycle.
`timescale 1ns/1ps
module flcfg_top_test;
  import flcfg_pkg::*;
  localparam int TW = 8000;
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] cfg;
    logic [7:0] pct;
  } flcfg_row_type;
  logic ref_clk, sys_rst, sclk, cs_n, si, so_o, so_oe, mem_wr, four_line_mode, oe;
  logic [7:0] mem_addr, mem_data, config_byte;
  logic [15:0] status_word, block_locks;
  logic [63:0] rx;
  flcfg_ctrl_type ctrl_view;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  flcfg_row_type rows [4] = '{'{8'h3b, 8'h23, DRV_PCT_01}, '{8'h5c, 8'h44, DRV_PCT_10},
    '{8'hf8, 8'he0, DRV_PCT_11}, '{8'h86, 8'h86, DRV_PCT_00}};

  flcfg_top #(.TW_NS(TW)) dut_u (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .SCLK(sclk),
    .CS_N(cs_n), .SI(si), .SO_O(so_o), .SO_OE(so_oe), .MEM_WR(mem_wr),
    .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .FOUR_LINE_MODE(four_line_mode),
    .STATUS_WORD(status_word), .CONFIG_BYTE(config_byte), .BLOCK_LOCKS(block_locks),
    .CTRL_VIEW(ctrl_view));
  flcfg_host host_u (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO_O(so_o), .SO_OE(so_oe));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Whole run needs about 21k cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic cmd(input logic [63:0] tx, input int ntx, input int nrx);
    host_u.frame(tx, ntx, nrx, rx, oe);
  endtask

  task automatic settle();
    for (int n = 0; n < 3000 && status_word[0] !== 1'b0; n++) @(negedge ref_clk);
  endtask

  task automatic reset_check();
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    check(status_word, 16'h0200, "status reset");
    check(config_byte, 8'h00, "config reset");
    check(block_locks, 16'hffff, "locks reset");
    check(ctrl_view.drive_pct, DRV_PCT_00, "drive reset");
    check(ctrl_view.fast_dummy, 4'h8, "fast dummy reset");
  endtask

  initial begin
    sys_rst = 1'b1;
    mem_wr = 1'b0;
    mem_addr = 8'h00;
    mem_data = 8'h00;
    four_line_mode = 1'b0;
    @(negedge ref_clk);
    reset_check();
    mem_wr = 1'b1;
    for (int a = 0; a < 256; a++) begin
      mem_addr = a[7:0];
      mem_data = a[7:0] ^ 8'h5a;
      @(negedge ref_clk);
    end
    mem_wr = 1'b0;
    foreach (rows[i]) begin
      cmd(WRITE_ENABLE_CMD, 8, 0);
      cmd({CONFIG_WRITE_CMD, rows[i].wr}, 16, 0);
      check(status_word[1:0], 2'b11, "busy after config write");
      settle();
      check(status_word[1:0], 2'b00, "busy and latch clear");
      check(config_byte, rows[i].cfg, "config byte");
      check(ctrl_view.hold_sel, rows[i].cfg[7], "hold select");
      check(ctrl_view.drive_pct, rows[i].pct, "drive");
      check(ctrl_view.lock_scheme, rows[i].cfg[2], "scheme");
      check({ctrl_view.dummy_2io, ctrl_view.dummy_4io, ctrl_view.dummy_dtr4},
        rows[i].cfg[1] ? 12'h8aa : 12'h468, "dummy counts");
      check(ctrl_view.learn_pattern, rows[i].cfg[0] ? 8'h34 : 8'h00, "pattern");
      cmd(CONFIG_READ_CMD, 8, 16);
      check(rx[15:0], {2{rows[i].cfg}}, "config read");
    end
    // Write without the latch must be dropped
    cmd({STATUS_WRITE_CMD, 8'hfc}, 16, 0);
    check(status_word, 16'h0200, "write without latch");
    cmd(WRITE_ENABLE_CMD, 8, 0);
    check(status_word[1], 1'b1, "latch set");
    cmd({STATUS_WRITE_CMD, 8'hff}, 16, 0);
    check(status_word, 16'h02ff, "one byte status write busy");
    cmd(CONFIG_READ_CMD, 8, 16);
    check(rx[15:0], 16'h8686, "config read while busy");
    cmd({FAST_ARRAY_READ_CMD, 32'h0}, 40, 8);
    check(oe, 1'b0, "fast read while busy");
    check(status_word[0], 1'b1, "cycle unaffected");
    settle();
    check(status_word, 16'h02fc, "status after cycle");
    cmd(WRITE_ENABLE_CMD, 8, 0);
    cmd({STATUS_WRITE_CMD, 8'h00, 8'hff}, 24, 0);
    settle();
    check(status_word, 16'h7b00, "two byte status write");
    cmd(WRITE_ENABLE_CMD, 8, 0);
    cmd({STATUS_HI_WRITE_CMD, 8'h00}, 16, 0);
    settle();
    check(status_word, 16'h0000, "upper status write");
    cmd(WRITE_ENABLE_CMD, 8, 0);
    cmd({STATUS_WRITE_CMD, 12'hfff}, 20, 0);
    check(status_word[15:2], 14'h0000, "odd bit count status");
    cmd({CONFIG_WRITE_CMD, 16'hffff}, 24, 0);
    check(config_byte, 8'h86, "two byte config write");
    cmd({ARRAY_READ_CMD, 24'hfffffe}, 32, 24);
    check(rx[23:0], 24'ha4a55a, "read across top");
    cmd({FAST_ARRAY_READ_CMD, 24'h0000ff, 8'h00}, 40, 16);
    check(rx[15:0], 16'ha55a, "fast read");
    cmd({ARRAY_READ_CMD, 24'h000010}, 32, 4);
    check(rx[3:0], 4'h4, "short read");
    check(so_oe, 1'b0, "output released");
    @(negedge ref_clk);
    four_line_mode = 1'b1;
    for (int p = 0; p < 4; p++) begin
      cmd({READ_PARAM_CMD, 2'b00, p[1:0], 4'h0}, 16, 0);
      check(ctrl_view.fast_dummy, p == 0 ? 4'h4 : p == 1 ? 4'h6 : 4'h8, "param dummy");
    end
    @(negedge ref_clk);
    four_line_mode = 1'b0;
    reset_check();
    report_and_stop();
  end
endmodule
